// [hw/fcf_consts.svh]
`ifndef FCF_CONSTS_SVH
`define FCF_CONSTS_SVH

// apb map, byte addresses
`define FCF_ADDR_W        8
`define FCF_OFF_A_LO      8'h00
`define FCF_OFF_A_MID     8'h04
`define FCF_OFF_A_HI      8'h08
`define FCF_OFF_B_LO      8'h0C
`define FCF_OFF_B_MID     8'h10
`define FCF_OFF_B_HI      8'h14
`define FCF_OFF_CMD       8'h18
`define FCF_OFF_SW        8'h1C
`define FCF_OFF_IFLAGS    8'h20
`define FCF_OFF_ACC       8'h24
`define FCF_OFF_MASK      8'h28
`define FCF_OFF_FEAT      8'h2C
`define FCF_OFF_IRQ_STS   8'h30
`define FCF_OFF_IRQ_CLR   8'h34
`define FCF_OFF_IRQ_EN    8'h38

// command word fields
`define FCF_CMD_OP_MSB    2
`define FCF_CMD_OP_LSB    0
`define FCF_CMD_A_EMPTY   4
`define FCF_CMD_B_EMPTY   5

// status word layout
`define FCF_SW_IE         0
`define FCF_SW_COND_LOW   8
`define FCF_SW_COND_SIGN  9
`define FCF_SW_COND_UNORD 10
`define FCF_SW_TOP_LSB    11
`define FCF_SW_TOP_MSB    13
`define FCF_SW_COND_EQ    14
`define FCF_SW_RESET      16'h0000

// integer flag register layout
`define FCF_IF_CARRY      0
`define FCF_IF_PARITY     2
`define FCF_IF_ZERO       6

// feature word, interrupt bits
`define FCF_FEAT_INT_CMP  0
`define FCF_IRQ_DONE      0
`define FCF_IRQ_INV       1
`define FCF_IRQ_W         2

// extended float fields
`define FCF_EXP_MAX       15'h7FFF
`define FCF_EXP_ZERO      15'h0000
`define FCF_QUIET_BIT     62

// examine codes as {cond_bit_equal, cond_bit_unordered, cond_bit_low}
`define FCF_XC_UNSUP      3'h0
`define FCF_XC_NAN        3'h1
`define FCF_XC_NORMAL     3'h2
`define FCF_XC_INF        3'h3
`define FCF_XC_ZERO       3'h4
`define FCF_XC_EMPTY      3'h5
`define FCF_XC_DENORM     3'h6

// compare codes as {zero_flag, parity_flag, carry_flag}
`define FCF_ZPC_GT        3'h0
`define FCF_ZPC_LT        3'h1
`define FCF_ZPC_EQ        3'h4
`define FCF_ZPC_UN        3'h7

`define FCF_MASK_UNORD    16'h0400

`endif

// [hw/fcf_pkg.sv]
`include "fcf_consts.svh"

package fcf_pkg;

  typedef enum logic [2:0] {
    fcf_op_compare_set_int_flags,
    fcf_op_compare_set_int_flags_pop,
    fcf_op_unordered_compare_set_int_flags,
    fcf_op_unordered_compare_set_int_flags_pop,
    fcf_op_examine_top_value,
    fcf_op_store_status_word,
    fcf_op_test_accumulator,
    fcf_op_none
  } fcf_op_t;

  typedef enum logic [2:0] {
    fcf_cls_unsupported,
    fcf_cls_nan,
    fcf_cls_normal,
    fcf_cls_infinity,
    fcf_cls_zero,
    fcf_cls_empty,
    fcf_cls_denormal
  } fcf_class_t;

  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] sig;
  } fcf_fp80_t;

  typedef struct packed {
    logic lt;
    logic eq;
    logic unord;
    logic invalid;
  } fcf_cmp_t;

  typedef struct packed {
    fcf_fp80_t                  stack_top;
    fcf_fp80_t                  stack_entry_n;
    logic                       top_empty;
    logic                       entry_empty;
    logic [15:0]                status_word;
    logic [2:0]                 zpc;
    logic [15:0]                accumulator;
    logic [15:0]                test_mask;
    logic                       pop_pend;
    logic [`FCF_IRQ_W-1:0]      irq_sts;
    logic [`FCF_IRQ_W-1:0]      irq_en;
    logic [31:0]                prdata;
  } fcf_state_t;

  // examine code for one class
  function automatic logic [2:0] exam_code(fcf_class_t c);
    logic [2:0] r;
    r = `FCF_XC_UNSUP;
    unique case (c)
      fcf_cls_unsupported: r = `FCF_XC_UNSUP;
      fcf_cls_nan:         r = `FCF_XC_NAN;
      fcf_cls_normal:      r = `FCF_XC_NORMAL;
      fcf_cls_infinity:    r = `FCF_XC_INF;
      fcf_cls_zero:        r = `FCF_XC_ZERO;
      fcf_cls_empty:       r = `FCF_XC_EMPTY;
      fcf_cls_denormal:    r = `FCF_XC_DENORM;
      default:             r = `FCF_XC_UNSUP;
    endcase
    return r;
  endfunction

endpackage

// [hw/fcf_classify.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcf_consts.svh"

module fcf_classify (
  // value under test
  input  wire fcf_pkg::fcf_fp80_t  val,
  input  wire logic                empty,
  // result
  output fcf_pkg::fcf_class_t      cls
);

  logic int_bit;
  logic frac_nz;

  assign int_bit = val.sig[63];
  assign frac_nz = |val.sig[62:0];

  // explicit integer bit makes unnormals, pseudo-nans and pseudo-infinities unsupported; pseudo-denormals count as denormal
  always_comb begin
    if (empty) begin
      cls = fcf_pkg::fcf_cls_empty;
    end else if (val.exp == `FCF_EXP_MAX) begin
      if (!int_bit)
        cls = fcf_pkg::fcf_cls_unsupported;
      else if (frac_nz)
        cls = fcf_pkg::fcf_cls_nan;
      else
        cls = fcf_pkg::fcf_cls_infinity;
    end else if (val.exp == `FCF_EXP_ZERO) begin
      if (val.sig == '0)
        cls = fcf_pkg::fcf_cls_zero;
      else
        cls = fcf_pkg::fcf_cls_denormal;
    end else if (!int_bit) begin
      cls = fcf_pkg::fcf_cls_unsupported;
    end else begin
      cls = fcf_pkg::fcf_cls_normal;
    end
  end

endmodule
`default_nettype wire

// [hw/fcf_compare.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcf_consts.svh"

module fcf_compare (
  // operands and their classes
  input  wire fcf_pkg::fcf_fp80_t  a,
  input  wire fcf_pkg::fcf_fp80_t  b,
  input  wire fcf_pkg::fcf_class_t cls_a,
  input  wire fcf_pkg::fcf_class_t cls_b,
  // high for the unordered-tolerant variants
  input  wire logic                quiet_ok,
  // result
  output fcf_pkg::fcf_cmp_t        res
);

  function automatic logic no_order(fcf_pkg::fcf_class_t c);
    return c == fcf_pkg::fcf_cls_nan || c == fcf_pkg::fcf_cls_unsupported
        || c == fcf_pkg::fcf_cls_empty;
  endfunction

  // signalling nan, unsupported or empty always faults
  function automatic logic loud(fcf_pkg::fcf_fp80_t v,
                                fcf_pkg::fcf_class_t c);
    return (c == fcf_pkg::fcf_cls_nan && !v.sig[`FCF_QUIET_BIT])
        || c == fcf_pkg::fcf_cls_unsupported
        || c == fcf_pkg::fcf_cls_empty;
  endfunction

  logic mag_gt;
  logic mag_eq;
  logic zeros;

  assign mag_gt = {a.exp, a.sig} > {b.exp, b.sig};
  assign mag_eq = {a.exp, a.sig} == {b.exp, b.sig};
  assign zeros  = cls_a == fcf_pkg::fcf_cls_zero
               && cls_b == fcf_pkg::fcf_cls_zero;

  always_comb begin
    res.unord   = no_order(cls_a) || no_order(cls_b);
    // quiet nans fault only in the ordinary variants
    res.invalid = res.unord
               && (!quiet_ok || loud(a, cls_a) || loud(b, cls_b));
    // signed zeros compare equal
    res.eq      = !res.unord && (zeros || (mag_eq && a.sign == b.sign));
    if (res.unord || res.eq)
      res.lt = 1'b0;
    else if (a.sign != b.sign)
      res.lt = a.sign;
    else
      res.lt = a.sign ? mag_gt : !mag_gt;
  end

endmodule
`default_nettype wire

// [hw/fcf_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcf_consts.svh"

module fcf_top #(
  parameter bit HAS_INT_CMP = 1'b1
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic [`FCF_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // core side results
  output logic                        zero_flag,
  output logic                        parity_flag,
  output logic                        carry_flag,
  output logic      [15:0]            accumulator_register,
  output logic      [15:0]            status_word,
  // interrupt
  output logic                        irq
);

  fcf_pkg::fcf_state_t s_r;
  fcf_pkg::fcf_state_t s_nxt;
  fcf_pkg::fcf_class_t cls_a;
  fcf_pkg::fcf_class_t cls_b;
  fcf_pkg::fcf_cmp_t   cmp;
  fcf_pkg::fcf_op_t    op;
  logic                setup;
  logic                access;
  logic                mapped;
  logic                wr;
  logic                wr_cmd;
  logic                is_cmp;
  logic                quiet_ok;
  logic [15:0]         tested;
  logic [31:0]         rd_word;

  function automatic logic is_mapped(logic [`FCF_ADDR_W-1:0] a);
    return a == `FCF_OFF_A_LO  || a == `FCF_OFF_A_MID  || a == `FCF_OFF_A_HI
        || a == `FCF_OFF_B_LO  || a == `FCF_OFF_B_MID  || a == `FCF_OFF_B_HI
        || a == `FCF_OFF_CMD   || a == `FCF_OFF_SW     || a == `FCF_OFF_IFLAGS
        || a == `FCF_OFF_ACC   || a == `FCF_OFF_MASK   || a == `FCF_OFF_FEAT
        || a == `FCF_OFF_IRQ_STS || a == `FCF_OFF_IRQ_CLR
        || a == `FCF_OFF_IRQ_EN;
  endfunction

  function automatic logic [2:0] zpc_of(fcf_pkg::fcf_cmp_t c);
    logic [2:0] r;
    r = `FCF_ZPC_GT;
    if (c.unord)
      r = `FCF_ZPC_UN;
    else if (c.eq)
      r = `FCF_ZPC_EQ;
    else if (c.lt)
      r = `FCF_ZPC_LT;
    return r;
  endfunction

  // operand that a tolerant compare lets through without a fault
  function automatic logic tolerated(fcf_pkg::fcf_fp80_t  v,
                                     fcf_pkg::fcf_class_t c);
    return !(c inside {fcf_pkg::fcf_cls_unsupported, fcf_pkg::fcf_cls_empty})
        && (c != fcf_pkg::fcf_cls_nan || v.sig[`FCF_QUIET_BIT]);
  endfunction

  fcf_classify u_cls_a (
    .val   (s_r.stack_top),
    .empty (s_r.top_empty),
    .cls   (cls_a)
  );

  fcf_classify u_cls_b (
    .val   (s_r.stack_entry_n),
    .empty (s_r.entry_empty),
    .cls   (cls_b)
  );

  fcf_compare u_cmp (
    .a        (s_r.stack_top),
    .b        (s_r.stack_entry_n),
    .cls_a    (cls_a),
    .cls_b    (cls_b),
    .quiet_ok (quiet_ok),
    .res      (cmp)
  );

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = is_mapped(paddr);
  assign wr     = access && pwrite && mapped;
  assign wr_cmd = wr && paddr == `FCF_OFF_CMD;
  assign op     = fcf_pkg::fcf_op_t'(pwdata[`FCF_CMD_OP_MSB:`FCF_CMD_OP_LSB]);
  // operands are loaded before the command, so they come from state
  assign is_cmp = HAS_INT_CMP && op inside {
    fcf_pkg::fcf_op_compare_set_int_flags,
    fcf_pkg::fcf_op_compare_set_int_flags_pop,
    fcf_pkg::fcf_op_unordered_compare_set_int_flags,
    fcf_pkg::fcf_op_unordered_compare_set_int_flags_pop};
  assign quiet_ok = op inside {
    fcf_pkg::fcf_op_unordered_compare_set_int_flags,
    fcf_pkg::fcf_op_unordered_compare_set_int_flags_pop};
  assign tested = s_r.accumulator & s_r.test_mask;

  always_comb begin
    rd_word = '0;
    unique case (paddr)
      `FCF_OFF_A_LO:    rd_word = s_r.stack_top.sig[31:0];
      `FCF_OFF_A_MID:   rd_word = s_r.stack_top.sig[63:32];
      `FCF_OFF_A_HI:    rd_word = {16'h0000, s_r.stack_top.sign,
                                   s_r.stack_top.exp};
      `FCF_OFF_B_LO:    rd_word = s_r.stack_entry_n.sig[31:0];
      `FCF_OFF_B_MID:   rd_word = s_r.stack_entry_n.sig[63:32];
      `FCF_OFF_B_HI:    rd_word = {16'h0000, s_r.stack_entry_n.sign,
                                   s_r.stack_entry_n.exp};
      `FCF_OFF_SW:      rd_word = {16'h0000, s_r.status_word};
      `FCF_OFF_IFLAGS: begin
        rd_word[`FCF_IF_ZERO]   = s_r.zpc[2];
        rd_word[`FCF_IF_PARITY] = s_r.zpc[1];
        rd_word[`FCF_IF_CARRY]  = s_r.zpc[0];
      end
      `FCF_OFF_ACC:     rd_word = {16'h0000, s_r.accumulator};
      `FCF_OFF_MASK:    rd_word = {16'h0000, s_r.test_mask};
      // advertised so software can probe before use
      `FCF_OFF_FEAT:    rd_word[`FCF_FEAT_INT_CMP] = HAS_INT_CMP;
      `FCF_OFF_IRQ_STS: rd_word[`FCF_IRQ_W-1:0] = s_r.irq_sts;
      `FCF_OFF_IRQ_EN:  rd_word[`FCF_IRQ_W-1:0] = s_r.irq_en;
      default:          rd_word = '0;
    endcase
  end

  always_comb begin
    logic [`FCF_IRQ_W-1:0] ev;
    logic [`FCF_IRQ_W-1:0] clr;
    logic [2:0]            top;
    ev    = '0;
    clr   = '0;
    s_nxt = s_r;
    top   = s_r.status_word[`FCF_SW_TOP_MSB:`FCF_SW_TOP_LSB];
    if (setup && !pwrite)
      s_nxt.prdata = rd_word;
    // pop lands one cycle after the flags were written
    s_nxt.pop_pend = 1'b0;
    if (s_r.pop_pend)
      s_nxt.status_word[`FCF_SW_TOP_MSB:`FCF_SW_TOP_LSB] = top + 3'h1;
    if (wr) begin
      unique case (paddr)
        `FCF_OFF_A_LO:  s_nxt.stack_top.sig[31:0]  = pwdata;
        `FCF_OFF_A_MID: s_nxt.stack_top.sig[63:32] = pwdata;
        `FCF_OFF_A_HI:  {s_nxt.stack_top.sign, s_nxt.stack_top.exp}
                          = pwdata[15:0];
        `FCF_OFF_B_LO:  s_nxt.stack_entry_n.sig[31:0]  = pwdata;
        `FCF_OFF_B_MID: s_nxt.stack_entry_n.sig[63:32] = pwdata;
        `FCF_OFF_B_HI:  {s_nxt.stack_entry_n.sign, s_nxt.stack_entry_n.exp}
                          = pwdata[15:0];
        `FCF_OFF_SW:    s_nxt.status_word = pwdata[15:0];
        `FCF_OFF_MASK:  s_nxt.test_mask   = pwdata[15:0];
        `FCF_OFF_IRQ_CLR: clr = pwdata[`FCF_IRQ_W-1:0];
        `FCF_OFF_IRQ_EN:  s_nxt.irq_en = pwdata[`FCF_IRQ_W-1:0];
        `FCF_OFF_CMD: begin
          s_nxt.top_empty   = pwdata[`FCF_CMD_A_EMPTY];
          s_nxt.entry_empty = pwdata[`FCF_CMD_B_EMPTY];
        end
        default: ;
      endcase
    end
    if (wr_cmd) begin
      ev[`FCF_IRQ_DONE] = 1'b1;
      if (is_cmp) begin
        // result goes to integer flags, codes untouched
        s_nxt.zpc = zpc_of(cmp);
        if (cmp.invalid) begin
          s_nxt.status_word[`FCF_SW_IE] = 1'b1;
          ev[`FCF_IRQ_INV] = 1'b1;
        end
        s_nxt.pop_pend = op inside {
          fcf_pkg::fcf_op_compare_set_int_flags_pop,
          fcf_pkg::fcf_op_unordered_compare_set_int_flags_pop};
      end else if (op == fcf_pkg::fcf_op_examine_top_value) begin
        // class code on the three condition bits
        {s_nxt.status_word[`FCF_SW_COND_EQ],
         s_nxt.status_word[`FCF_SW_COND_UNORD],
         s_nxt.status_word[`FCF_SW_COND_LOW]} = fcf_pkg::exam_code(cls_a);
        s_nxt.status_word[`FCF_SW_COND_SIGN] = s_r.stack_top.sign;
      end else if (op == fcf_pkg::fcf_op_store_status_word) begin
        s_nxt.accumulator = s_r.status_word;
      end else if (op == fcf_pkg::fcf_op_test_accumulator) begin
        // bit test against the mask register
        s_nxt.zpc = {tested == '0, ~^tested[7:0], 1'b0};
      end
    end
    // a new event beats a clear in the same cycle
    s_nxt.irq_sts = (s_r.irq_sts & ~clr) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r             <= '0;
      s_r.status_word <= `FCF_SW_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata               = s_r.prdata;
  assign pready               = 1'b1;
  assign pslverr              = access && !mapped;
  assign zero_flag            = s_r.zpc[2];
  assign parity_flag          = s_r.zpc[1];
  assign carry_flag           = s_r.zpc[0];
  assign accumulator_register = s_r.accumulator;
  assign status_word          = s_r.status_word;
  assign irq                  = |(s_r.irq_sts & s_r.irq_en);

  a_cmp_less: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && cmp.lt |=> s_r.zpc == `FCF_ZPC_LT)
    else $error("less than did not give carry only");

  a_cmp_unord: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && cmp.unord |=> {zero_flag, parity_flag, carry_flag}
      == `FCF_ZPC_UN)
    else $error("unordered did not set all three flags");

  a_cmp_equal: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && cmp.eq
      |=> {zero_flag, parity_flag, carry_flag} == `FCF_ZPC_EQ)
    else $error("equal did not give zero only");

  a_ord_invalid: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && !quiet_ok && cmp.unord
      |=> status_word[`FCF_SW_IE] && s_r.irq_sts[`FCF_IRQ_INV])
    else $error("ordinary compare missed invalid on unordered");

  a_cmp_greater: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && !cmp.unord && !cmp.eq && !cmp.lt
      |=> s_r.zpc == `FCF_ZPC_GT && $stable(s_r.status_word[`FCF_SW_COND_EQ]))
    else $error("greater did not clear flags");

  a_feature_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FCF_OFF_FEAT
      |=> prdata[`FCF_FEAT_INT_CMP] == HAS_INT_CMP)
    else $error("feature bit misreported");

  a_quiet_nan: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && quiet_ok && cmp.unord
      && tolerated(s_r.stack_top, cls_a)
      && tolerated(s_r.stack_entry_n, cls_b)
      |=> s_r.status_word[`FCF_SW_IE] == $past(s_r.status_word[`FCF_SW_IE]))
    else $error("quiet nan raised invalid");

  a_pop_after: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && is_cmp && s_nxt.pop_pend && !s_r.pop_pend
      ##1 !wr ##1 !wr
      |-> s_r.status_word[`FCF_SW_TOP_MSB:`FCF_SW_TOP_LSB]
        == $past(s_r.status_word[`FCF_SW_TOP_MSB:`FCF_SW_TOP_LSB], 2)
           + 3'h1)
    else $error("pop did not advance stack pointer once");

  a_exam_class: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && op == fcf_pkg::fcf_op_examine_top_value
      |=> {status_word[`FCF_SW_COND_EQ], status_word[`FCF_SW_COND_UNORD],
           status_word[`FCF_SW_COND_LOW]} == fcf_pkg::exam_code($past(cls_a)))
    else $error("examine class code wrong");

  a_exam_sign: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && op == fcf_pkg::fcf_op_examine_top_value
      |=> status_word[`FCF_SW_COND_SIGN] == $past(s_r.stack_top.sign))
    else $error("examine sign bit wrong");

  a_store_acc: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && op == fcf_pkg::fcf_op_store_status_word
      |=> accumulator_register == $past(s_r.status_word))
    else $error("status word not copied to accumulator");

  a_test_unord: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd && op == fcf_pkg::fcf_op_test_accumulator
      && s_r.test_mask == `FCF_MASK_UNORD
      |=> zero_flag == !$past(s_r.accumulator[`FCF_SW_COND_UNORD]))
    else $error("unordered mask test gave wrong zero flag");

endmodule
`default_nettype wire

// [test/fcf_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcf_consts.svh"

module tb;
  typedef struct packed {
    logic [15:0] sa;
    logic [63:0] ma;
    logic [15:0] sb;
    logic [63:0] mb;
    logic [1:0]  emp;
    logic [2:0]  zpc;
    logic        inv_ord;
    logic        inv_tol;
  } fcf_cmp_case_t;

  typedef struct packed {
    logic [15:0] sa;
    logic [63:0] ma;
    logic [1:0]  emp;
    logic [2:0]  code;
  } fcf_exam_case_t;

  localparam logic [63:0] M1  = 64'h8000_0000_0000_0000;
  localparam logic [63:0] MQN = 64'hC000_0000_0000_0000;
  localparam logic [63:0] MSN = 64'hA000_0000_0000_0000;
  localparam int          TMO = 20000;

  // {zero, parity, carry}: gt 000, lt 001, eq 100, unordered 111
  localparam fcf_cmp_case_t CMP [7] = '{
    '{16'h4000, M1, 16'h3FFF, M1, 2'h0, 3'h0, 1'b0, 1'b0},
    '{16'hBFFF, M1, 16'hC000, M1, 2'h0, 3'h0, 1'b0, 1'b0},
    '{16'h3FFF, M1, 16'h4000, M1, 2'h0, 3'h1, 1'b0, 1'b0},
    '{16'h0000, 64'h0, 16'h8000, 64'h0, 2'h0, 3'h4, 1'b0, 1'b0},
    '{16'h7FFF, MQN, 16'h3FFF, M1, 2'h0, 3'h7, 1'b1, 1'b0},
    '{16'h3FFF, M1, 16'h7FFF, MSN, 2'h0, 3'h7, 1'b1, 1'b1},
    '{16'h3FFF, M1, 16'h3FFF, M1, 2'h2, 3'h7, 1'b1, 1'b1}
  };

  localparam fcf_exam_case_t EXM [7] = '{
    '{16'h0000, 64'h0, 2'h0, `FCF_XC_ZERO},
    '{16'h8000, 64'h1, 2'h0, `FCF_XC_DENORM},
    '{16'h3FFF, M1, 2'h0, `FCF_XC_NORMAL},
    '{16'hFFFF, M1, 2'h0, `FCF_XC_INF},
    '{16'h7FFF, MQN, 2'h0, `FCF_XC_NAN},
    '{16'hBFFF, 64'h0, 2'h0, `FCF_XC_UNSUP},
    '{16'h0000, M1, 2'h1, `FCF_XC_EMPTY}
  };

  // {status word, test mask}
  localparam logic [31:0] TST [7] = '{
    32'h4500_0400, 32'h4000_0400, 32'h0000_4500, 32'h4100_4500,
    32'h0100_0100, 32'h4000_4000, 32'h0007_00FF
  };

  logic                   pclk;
  logic                   presetn;
  logic [`FCF_ADDR_W-1:0] paddr;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [31:0]            pwdata;
  wire logic [31:0]       prdata;
  wire logic              pready;
  wire logic              pslverr;
  wire logic              zero_flag;
  wire logic              parity_flag;
  wire logic              carry_flag;
  wire logic [15:0]       accumulator_register;
  wire logic [15:0]       status_word;
  wire logic              irq;
  logic [31:0]            rdata;
  logic                   rerr;
  logic [15:0]            r;
  int                     n_errors;
  int                     samples_checked;
  int                     cycles;

  fcf_top dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .zero_flag            (zero_flag),
    .parity_flag          (parity_flag),
    .carry_flag           (carry_flag),
    .accumulator_register (accumulator_register),
    .status_word          (status_word),
    .irq                  (irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%08h expected=%08h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // empty bits act on the next command, so they go in a no-op first
  task automatic cmd(input logic [2:0] op, input logic [1:0] emp);
    wr(`FCF_OFF_CMD, {26'h0, emp, 1'b0, 3'h7});
    wr(`FCF_OFF_CMD, {26'h0, emp, 1'b0, op});
  endtask

  task automatic ld(input logic [15:0] sa, input logic [63:0] ma,
                    input logic [15:0] sb, input logic [63:0] mb);
    wr(`FCF_OFF_A_LO, ma[31:0]);
    wr(`FCF_OFF_A_MID, ma[63:32]);
    wr(`FCF_OFF_A_HI, {16'h0, sa});
    wr(`FCF_OFF_B_LO, mb[31:0]);
    wr(`FCF_OFF_B_MID, mb[63:32]);
    wr(`FCF_OFF_B_HI, {16'h0, sb});
  endtask

  function automatic logic [31:0] iflag(input logic [2:0] zpc);
    return {25'h0, zpc[2], 3'h0, zpc[1], 1'b0, zpc[0]};
  endfunction

  always @(posedge pclk) begin
    cycles++;
    if (cycles == TMO) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;

    rd(`FCF_OFF_FEAT);
    check(rdata, 32'h1);
    rd(`FCF_OFF_SW);
    check(rdata, 32'h0);
    rd(8'h3C);
    check({rdata[30:0], rerr}, 32'h1);
    check({31'h0, pready}, 32'h1);
    $display("test reset_and_map done");

    foreach (CMP[i]) begin
      for (int op = 0; op < 4; op++) begin
        ld(CMP[i].sa, CMP[i].ma, CMP[i].sb, CMP[i].mb);
        wr(`FCF_OFF_IRQ_CLR, 32'h3);
        wr(`FCF_OFF_SW, 32'h0);
        cmd(op[2:0], CMP[i].emp);
        rd(`FCF_OFF_IFLAGS);
        check(rdata, iflag(CMP[i].zpc));
        check({zero_flag, parity_flag, carry_flag}, CMP[i].zpc);
        r = 16'h0;
        r[0] = op[1] ? CMP[i].inv_tol : CMP[i].inv_ord;
        rd(`FCF_OFF_IRQ_STS);
        check(rdata, {30'h0, r[0], 1'b1});
        r[11] = op[0];
        rd(`FCF_OFF_SW);
        check(rdata & 32'h3801, {16'h0, r});
      end
    end
    $display("test compare_flags done");

    foreach (EXM[i]) begin
      ld(EXM[i].sa, EXM[i].ma, 16'h3FFF, M1);
      cmd(3'h4, EXM[i].emp);
      r = {1'b0, EXM[i].code[2], 3'h0, EXM[i].code[1], 1'b0,
           EXM[i].code[0], 8'h0};
      r[9] = EXM[i].sa[15];
      rd(`FCF_OFF_SW);
      // sign of an empty register carries no meaning
      if (EXM[i].emp[0]) begin
        check(rdata & 32'h4500, {16'h0, r});
      end else begin
        check(rdata & 32'h4700, {16'h0, r});
      end
      r = rdata[15:0];
      cmd(3'h5, 2'h0);
      rd(`FCF_OFF_ACC);
      check(rdata, {16'h0, r});
      check({accumulator_register, status_word}, {r, r});
    end
    $display("test examine_store done");

    foreach (TST[i]) begin
      wr(`FCF_OFF_SW, {16'h0, TST[i][31:16]});
      cmd(3'h5, 2'h0);
      wr(`FCF_OFF_MASK, {16'h0, TST[i][15:0]});
      cmd(3'h6, 2'h0);
      r = TST[i][31:16] & TST[i][15:0];
      rd(`FCF_OFF_IFLAGS);
      check(rdata, iflag({r == 16'h0, ~^r[7:0], 1'b0}));
    end
    $display("test status_mask done");

    wr(`FCF_OFF_IRQ_EN, 32'h3);
    wr(`FCF_OFF_IRQ_CLR, 32'h3);
    rd(`FCF_OFF_IRQ_EN);
    check({rdata[30:0], irq}, 32'h6);
    cmd(3'h5, 2'h0);
    rd(`FCF_OFF_IRQ_STS);
    check({rdata[30:0], irq}, 32'h3);
    wr(`FCF_OFF_IRQ_CLR, 32'h1);
    rd(`FCF_OFF_IRQ_CLR);
    check({rdata[30:0], irq}, 32'h0);
    wr(`FCF_OFF_IRQ_EN, 32'h0);
    cmd(3'h5, 2'h0);
    rd(`FCF_OFF_IRQ_STS);
    // masked event stays recorded but keeps the line low
    check({rdata[30:0], irq}, 32'h2);
    $display("test interrupt done");

    end_of_test();
  end
endmodule

`default_nettype wire
